// ==== hw/timer8_pkg.sv ====
/*
 package of the 8-bit timer capture and waveform block: register
 offsets, field positions, reset values, divider count and the
 packed carriers shared by the top level and its two leaf modules.
 assumes an 8-bit register port with a 4-bit word address.
*/
package timer8_pkg;

   // register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [3:0] CONTROL_ADDR = 4'h0;
   localparam logic [3:0] COMPARE_ONE_ADDR = 4'h1;
   localparam logic [3:0] COMPARE_TWO_ADDR = 4'h2;
   localparam logic [3:0] COUNTER_ADDR = 4'h3;
   localparam logic [3:0] CAPTURE_ONE_ADDR = 4'h4;
   localparam logic [3:0] CAPTURE_TWO_ADDR = 4'h5;
   localparam logic [3:0] STATUS_ADDR = 4'h6;
   localparam logic [3:0] IRQ_CLEAR_ADDR = 4'h7;
   localparam logic [3:0] IRQ_ENABLE_ADDR = 4'h8;
   localparam logic [3:0] PIN_STATE_ADDR = 4'h9;

   // control register fields
   localparam int CTL_TIMER_EN = 0;
   localparam int CTL_PWM_EN = 1;
   localparam int CTL_ONE_PULSE = 2;
   localparam int CTL_EDGE_ONE = 3;
   localparam int CTL_EDGE_TWO = 4;
   localparam int CTL_LEVEL_ONE = 5;
   localparam int CTL_LEVEL_TWO = 6;

   // event bits of status, clear and enable registers
   localparam int EVT_W = 5;
   localparam int EVT_CAPTURE_ONE = 0;
   localparam int EVT_CAPTURE_TWO = 1;
   localparam int EVT_COMPARE_ONE = 2;
   localparam int EVT_COMPARE_TWO = 3;
   localparam int EVT_OVERFLOW = 4;

   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] COMPARE_RESET = 8'h00;
   localparam logic [4:0] IRQ_ENABLE_RESET = 5'h00;
   localparam logic PIN_RESET = 1'b0;

   // counter values
   localparam logic [7:0] COUNT_TOP = 8'hFF;
   localparam logic [7:0] COUNT_ZERO = 8'h00;

   // timer tick divider: one tick every TICK_DIV clock cycles
   localparam int TICK_DIV = 4;
   localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);

   // one register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

   // control register layout
   typedef struct packed {
      logic spare;
      logic level_two;
      logic level_one;
      logic edge_two;
      logic edge_one;
      logic one_pulse;
      logic pwm_en;
      logic timer_en;
   } control_t;

endpackage

// ==== hw/capture_edge.sv ====
/*
 edge detector of one input capture channel: a one-cycle pulse on
 the selected transition of the capture input while enabled.
 assumes the input is synchronous to the clock.
*/
`timescale 1ns/1ps
module capture_edge (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // channel control
   input wire logic enable_i,
   input wire logic edge_rising_i,
   // capture pin and event
   input wire logic sample_i,
   output logic event_o
);
   import timer8_pkg::*;

   typedef struct packed {
      logic primed;
      logic prev;
   } edge_state_t;

   edge_state_t state_reg;
   edge_state_t state_next;

   // remember last level; first sample after reset only primes
   always_comb begin
      state_next = state_reg;
      state_next.prev = sample_i;
      state_next.primed = 1'b1;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   always_comb begin
      if (edge_rising_i) begin
         event_o = enable_i & state_reg.primed & sample_i & ~state_reg.prev;
      end else begin
         event_o = enable_i & state_reg.primed & ~sample_i & state_reg.prev;
      end
   end

endmodule // capture_edge

// ==== hw/event_status.sv ====
/*
 sticky event flags with write-one-to-clear, an enable register of
 the same layout and one level interrupt output.
 assumes event pulses and strobes come from the same clock.
*/
`timescale 1ns/1ps
module event_status (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // events
   input wire logic [timer8_pkg::EVT_W-1:0] set_i,
   // software access
   input wire logic clear_wr_i,
   input wire logic enable_wr_i,
   input wire logic [timer8_pkg::EVT_W-1:0] data_i,
   // state
   output logic [timer8_pkg::EVT_W-1:0] status_o,
   output logic [timer8_pkg::EVT_W-1:0] enable_o,
   output logic irq_o
);
   import timer8_pkg::*;

   typedef struct packed {
      logic [EVT_W-1:0] status;
      logic [EVT_W-1:0] enable;
   } evt_state_t;

   evt_state_t state_reg;
   evt_state_t state_next;

   // a set in the clearing cycle wins over the clear
   always_comb begin
      state_next = state_reg;
      if (clear_wr_i) begin
         state_next.status = state_reg.status & ~data_i;
      end
      state_next.status = state_next.status | set_i;
      if (enable_wr_i) begin
         state_next.enable = data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg.status <= '0;
         state_reg.enable <= IRQ_ENABLE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs
   assign status_o = state_reg.status;
   assign enable_o = state_reg.enable;
   assign irq_o = |(state_reg.status & state_reg.enable);

endmodule // event_status

// ==== hw/timer8_capture_pwm.sv ====
/*
 capture and waveform part of an 8-bit free-running timer: two
 capture channels, two compare registers, one compare output pin,
 a pulse width modulation mode, sticky event flags and interrupt.
 assumes all inputs synchronous to clk_i and a register master that
 never asserts both strobes in one cycle.
*/
// Behaviour
// - two capture channels, each configured separately
// - edge select 0 falling, 1 rising
// - modulation or one-pulse: only channel two captures
// - valid edge sets a readable capture flag
// - both modes on: modulation wins, one-pulse ignored
// - compare values and levels shape the waveform
// - first compare match drives level one; one-pulse mode holds the pin instead
// - second match drives same pin, level two, only in modulation
// - no compare flags in modulation mode
// - modulation: second match sets capture one flag

`timescale 1ns/1ps
module timer8_capture_pwm (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // register port
   input wire timer8_pkg::bus_req_t bus_i,
   output logic [timer8_pkg::DATA_W-1:0] rdata_o,
   // capture pins
   input wire logic capture_input_one_i,
   input wire logic capture_input_two_i,
   // compare pin and interrupt
   output logic compare_output_one_o,
   output logic irq_o
);
   import timer8_pkg::*;

   // register map, one byte each
   //   0 control, bit 7 reads 0
   //   1 compare value one
   //   2 compare value two
   //   3 counter, read only; any write restarts count and divider
   //   4 capture one, count latched on a channel one edge
   //   5 capture two, count latched on a channel two edge
   //   6 status: sticky event flags, read only
   //   7 interrupt clear: a one clears that flag, write only
   //   8 interrupt enable, same layout as status
   //   9 pin state: bit 0 is the compare output pin
   //   other addresses read 0 and ignore writes
   // control bits: 0 timer enable, 1 modulation, 2 one-pulse,
   //   3 and 4 edge of channel one and two (1 rising), 5 and 6 levels
   // event bits: 0 capture one, 1 capture two, 2 compare one,
   //   3 compare two, 4 counter wrap

   // whole state of the block
   typedef struct packed {
      control_t ctrl;
      logic [7:0] compare_value_one;
      logic [7:0] compare_value_two;
      logic [7:0] count;
      logic [7:0] capture_one;
      logic [7:0] capture_two;
      logic [1:0] div;
      logic pin;
      logic [7:0] rdata;
   } top_state_t;

   top_state_t state_reg;
   top_state_t state_next;

   logic [1:0] rst_sync_reg;
   logic rst_n;

   // decoded modes and events
   logic pwm_active;
   logic one_pulse_mode;
   logic cap_one_enable;
   logic cap_two_enable;
   logic tick;
   logic match_one;
   logic match_two;
   logic overflow;
   logic [1:0] cap_event;

   // flag block connections
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_status;
   logic [EVT_W-1:0] evt_enable;
   logic clear_wr;
   logic enable_wr;

   // capture channel vectors
   logic [1:0] cap_pin;
   logic [1:0] cap_rising;
   logic [1:0] cap_en;

   // reset release through two flops: the raw reset only clears
   // these two, the rest leaves reset on the second edge after
   // release, so no flop sees its reset end close to an edge
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // mode decode: modulation, then one-pulse, then plain compare
   // modulation has priority over one-pulse
   assign pwm_active = state_reg.ctrl.pwm_en;
   assign one_pulse_mode = state_reg.ctrl.one_pulse & ~pwm_active;

   // first channel lost in either mode
   assign cap_one_enable = state_reg.ctrl.timer_en & ~pwm_active &
                           ~one_pulse_mode;
   assign cap_two_enable = state_reg.ctrl.timer_en;

   // counter tick from the divider
   // one clock in TICK_DIV, and none while the timer is stopped
   assign tick = state_reg.ctrl.timer_en & (state_reg.div == TICK_LAST);

   // compare matches on the count value seen at the tick
   // a match counts once, on the tick that sees the equal count
   assign match_one = tick &
                      (state_reg.count == state_reg.compare_value_one);
   assign match_two = tick &
                      (state_reg.count == state_reg.compare_value_two);

   // wrap of the free-running count, not a modulation restart
   assign overflow = tick & (state_reg.count == COUNT_TOP) &
                     ~(pwm_active & match_two);

   // channel one loses its pin whenever either waveform mode is on;
   // channel two only needs the timer enabled. an edge latches the
   // count and raises the channel's flag; in modulation the period
   // match raises flag one in place of the disabled channel one edge

   // per-channel control vectors, channel one in bit 0
   assign cap_pin = {capture_input_two_i, capture_input_one_i};
   assign cap_rising = {state_reg.ctrl.edge_two, state_reg.ctrl.edge_one};
   assign cap_en = {cap_two_enable, cap_one_enable};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_capture
         capture_edge u_edge (
            .clk_i(clk_i),
            .rst_n_i(rst_n),
            .enable_i(cap_en[ch]),
            .edge_rising_i(cap_rising[ch]),
            .sample_i(cap_pin[ch]),
            .event_o(cap_event[ch])
         );
      end
   endgenerate

   // event vector feeding the sticky flags
   always_comb begin
      evt_set = '0;
      evt_set[EVT_CAPTURE_ONE] = cap_event[0];
      evt_set[EVT_CAPTURE_TWO] = cap_event[1];
      if (pwm_active && match_two) begin
         evt_set[EVT_CAPTURE_ONE] = 1'b1;
      end
      // compare flags held off in modulation
      evt_set[EVT_COMPARE_ONE] = match_one & ~pwm_active;
      evt_set[EVT_COMPARE_TWO] = match_two & ~pwm_active;
      evt_set[EVT_OVERFLOW] = overflow;
   end

   // write strobes for the flag block
   assign clear_wr = bus_i.wr & (bus_i.addr == IRQ_CLEAR_ADDR);
   assign enable_wr = bus_i.wr & (bus_i.addr == IRQ_ENABLE_ADDR);

   // one level interrupt, high while any enabled flag is set; a set
   // and a clear in one cycle leave the flag set, so none is lost
   event_status u_status (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .set_i(evt_set),
      .clear_wr_i(clear_wr),
      .enable_wr_i(enable_wr),
      .data_i(bus_i.wdata[EVT_W-1:0]),
      .status_o(evt_status),
      .enable_o(evt_enable),
      .irq_o(irq_o)
   );

   // modulation timing, one tick being TICK_DIV clocks:
   //   tick seeing count equal to compare one: pin takes level one
   //   tick seeing count equal to compare two: pin takes level two,
   //   the count restarts at zero and flag one is raised
   //   level one lasts (two - one) ticks, level two (one + 1) ticks
   //   both matches in one tick: level two wins, the period ends
   //   compare one at or above compare two keeps the pin at level two
   //   values above FC are stored as written and left to software
   // outside modulation match one drives level one unless one-pulse
   // mode holds the pin, and match two only raises its own flag

   // next state: divider, counter, pin, captures, registers, read
   always_comb begin
      state_next = state_reg;

      // divider runs only while the timer is enabled
      // stopping or a counter write restarts it from zero
      if (!state_reg.ctrl.timer_en || tick) begin
         state_next.div = 2'b00;
      end else begin
         state_next.div = state_reg.div + 2'b01;
      end

      // free-running count
      if (tick) begin
         state_next.count = state_reg.count + 8'h01;
      end
      if (pwm_active && match_two) begin
         state_next.count = COUNT_ZERO;
      end

      if (pwm_active) begin
         // second match drives the same pin
         if (match_two) begin
            state_next.pin = state_reg.ctrl.level_two;
         end else if (match_one) begin
            state_next.pin = state_reg.ctrl.level_one;
         end
      end else if (match_one && !one_pulse_mode) begin
         state_next.pin = state_reg.ctrl.level_one;
      end

      // latch the count on each capture
      // a later edge overwrites a capture software has not read
      if (cap_event[0]) begin
         state_next.capture_one = state_reg.count;
      end
      if (cap_event[1]) begin
         state_next.capture_two = state_reg.count;
      end

      // register writes
      if (bus_i.wr) begin
         case (bus_i.addr)
            CONTROL_ADDR: begin
               state_next.ctrl = control_t'(bus_i.wdata);
               state_next.ctrl.spare = 1'b0;
            end
            COMPARE_ONE_ADDR: begin
               state_next.compare_value_one = bus_i.wdata;
            end
            COMPARE_TWO_ADDR: begin
               state_next.compare_value_two = bus_i.wdata;
            end
            COUNTER_ADDR: begin
               // any write restarts the count and divider
               state_next.count = COUNT_ZERO;
               state_next.div = 2'b00;
            end
            // flag clear and enable live in the flag block
            IRQ_CLEAR_ADDR, IRQ_ENABLE_ADDR: begin
            end
            // read-only registers ignore writes
            CAPTURE_ONE_ADDR, CAPTURE_TWO_ADDR, STATUS_ADDR,
            PIN_STATE_ADDR: begin
            end
            default: begin
            end
         endcase
      end

      // read data stand for one cycle only
      // then return to zero, so a stale value never looks fresh
      state_next.rdata = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            CONTROL_ADDR: begin
               state_next.rdata = state_reg.ctrl;
            end
            COMPARE_ONE_ADDR: begin
               state_next.rdata = state_reg.compare_value_one;
            end
            COMPARE_TWO_ADDR: begin
               state_next.rdata = state_reg.compare_value_two;
            end
            COUNTER_ADDR: begin
               state_next.rdata = state_reg.count;
            end
            CAPTURE_ONE_ADDR: begin
               state_next.rdata = state_reg.capture_one;
            end
            CAPTURE_TWO_ADDR: begin
               state_next.rdata = state_reg.capture_two;
            end
            STATUS_ADDR: begin
               state_next.rdata = {3'h0, evt_status};
            end
            IRQ_ENABLE_ADDR: begin
               state_next.rdata = {3'h0, evt_enable};
            end
            PIN_STATE_ADDR: begin
               state_next.rdata = {7'h00, state_reg.pin};
            end
            default: begin
               state_next.rdata = 8'h00;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg.ctrl <= control_t'(CONTROL_RESET);
         state_reg.compare_value_one <= COMPARE_RESET;
         state_reg.compare_value_two <= COMPARE_RESET;
         state_reg.count <= COUNT_ZERO;
         state_reg.capture_one <= 8'h00;
         state_reg.capture_two <= 8'h00;
         state_reg.div <= 2'b00;
         state_reg.pin <= PIN_RESET;
         state_reg.rdata <= 8'h00;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs from flops
   // pin and read data leave flops, so no decode glitch reaches them
   assign rdata_o = state_reg.rdata;
   assign compare_output_one_o = state_reg.pin;

endmodule // timer8_capture_pwm

// ==== tb/timer8_asserts.sv ====
/*
 port checker of the timer capture and waveform block: read data
 timing, compare pin levels and interrupt, from shadowed writes.
 assumes it is bound into timer8_capture_pwm.
*/
`timescale 1ns/1ps
module timer8_asserts (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // register port
   input wire timer8_pkg::bus_req_t bus_i,
   input wire logic [timer8_pkg::DATA_W-1:0] rdata_o,
   // pin and interrupt
   input wire logic compare_output_one_o,
   input wire logic irq_o
);
   import timer8_pkg::*;
   control_t ctl_reg;
   logic [EVT_W-1:0] en_reg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // shadow of control and interrupt enable writes
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctl_reg <= CONTROL_RESET;
         en_reg <= IRQ_ENABLE_RESET;
      end else if (bus_i.wr && bus_i.addr == CONTROL_ADDR) begin
         ctl_reg <= bus_i.wdata;
      end else if (bus_i.wr && bus_i.addr == IRQ_ENABLE_ADDR) begin
         en_reg <= bus_i.wdata[EVT_W-1:0];
      end
   end
   // one read request at a given address
   sequence s_read(logic [3:0] a);
      bus_i.rd && bus_i.addr == a;
   endsequence
   a_rdata_idle: assert property (!bus_i.rd |=> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   a_ctl_readback: assert property (s_read(CONTROL_ADDR) |=>
      rdata_o == (8'($past(ctl_reg)) & 8'h7F))
      else $error("control read back wrong");
   a_status_irq: assert property (s_read(STATUS_ADDR) |=>
      $past(irq_o) == |(rdata_o[EVT_W-1:0] & $past(en_reg)))
      else $error("interrupt disagrees with status and enable");
   a_irq_masked: assert property (en_reg == 5'h00 |-> !irq_o)
      else $error("interrupt with nothing enabled");
   a_pin_frozen: assert property (!ctl_reg.timer_en
      && !$past(ctl_reg.timer_en) |-> $stable(compare_output_one_o))
      else $error("compare pin moved while timer stopped");
   a_pin_rise: assert property ($rose(compare_output_one_o) |->
      $past(ctl_reg.level_one) || $past(ctl_reg.pwm_en)
      && $past(ctl_reg.level_two))
      else $error("compare pin rose with no high level set");
   a_pin_fall: assert property ($fell(compare_output_one_o) |->
      !$past(ctl_reg.level_one) || $past(ctl_reg.pwm_en)
      && !$past(ctl_reg.level_two))
      else $error("compare pin fell with no low level set");
   a_pin_readback: assert property (s_read(PIN_STATE_ADDR) |=>
      rdata_o == {7'h00, $past(compare_output_one_o)})
      else $error("pin state read back wrong");
endmodule // timer8_asserts

bind timer8_capture_pwm timer8_asserts timer8_asserts_i (
   .clk_i(clk_i),
   .resetn_i(resetn_i),
   .bus_i(bus_i),
   .rdata_o(rdata_o),
   .compare_output_one_o(compare_output_one_o),
   .irq_o(irq_o)
);

// ==== tb/capture_pins.sv ====
/*
 far side model: drives the two capture pins from levels the bench
 asks for, changing them only just after a clock edge.
 assumes the bench requests levels on the same clock.
*/
`timescale 1ns/1ps
module capture_pins (
   // clock
   input wire logic clk_i,
   // requested levels
   input wire logic [1:0] level_i,
   // capture pins
   output logic [1:0] pin_o
);
   // pins start low and follow the request one clock later
   initial pin_o = 2'b00;
   always @(posedge clk_i) begin
      pin_o <= level_i;
   end
endmodule // capture_pins

// ==== tb/tb_top.sv ====
/*
 self-checking bench of the timer capture and waveform block:
 capture edges, mode refusals, modulation spans and interrupt.
 assumes the checker is bound in and the far side model is present.
*/
`timescale 1ns/1ps
module tb_top;
   import timer8_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   bus_req_t bus = '0;
   logic [7:0] rdata, v, c1, c2;
   logic [1:0] lvl = 2'b00;
   logic [1:0] cap;
   logic pin, irq, l1, op;
   int n;
   int error_cnt = 0;
   int checked = 0;

   timer8_capture_pwm timer8_capture_pwm_i (.clk_i(clk_i),
      .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata),
      .capture_input_one_i(cap[0]), .capture_input_two_i(cap[1]),
      .compare_output_one_o(pin), .irq_o(irq));
   capture_pins capture_pins_i (.clk_i(clk_i), .level_i(lvl), .pin_o(cap));

   // clock of 8 ns
   initial begin
      forever #4 clk_i = ~clk_i;
   end

   function automatic logic [15:0] ticks(input int t);
      return 16'(TICK_DIV * t);
   endfunction

   task automatic chk(input string what, input logic [15:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one write cycle, then a quiet cycle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge clk_i);
      bus.wr <= 1'b0;
      @(posedge clk_i);
   endtask

   // one read cycle, data taken in the cycle after it
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge clk_i);
      bus.rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk_i);
   endtask

   // cycles the compare pin holds level lv
   task automatic span(input logic lv, output int k);
      k = 0;
      while (pin === lv && k < 2100) begin
         @(posedge clk_i);
         #1 k++;
      end
   endtask

   task automatic give_verdict();
      if (error_cnt == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (40000) @(posedge clk_i);
      error_cnt++;
      give_verdict();
   end

   initial begin
      void'($urandom(32'h00ead560));
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      // reset values and the six unmapped addresses
      for (int a = 0; a < 16; a++) begin
         rd(4'(a), v);
         chk("reset read", v, 8'h00);
      end
      // each channel flags only its selected transition
      for (int ch = 0; ch < 2; ch++) begin
         for (int e = 0; e < 2; e++) begin
            lvl[ch] <= e[0];
            wr(CONTROL_ADDR, 8'h01 | 8'(1 << (CTL_EDGE_ONE + ch + 0 * e))
               & {8{e[0]}} | 8'h01);
            wr(IRQ_CLEAR_ADDR, 8'h1F);
            lvl[ch] <= ~e[0];
            repeat (4) @(posedge clk_i);
            rd(STATUS_ADDR, v);
            chk("wrong edge flags", v & 8'h03, 8'h00);
            lvl[ch] <= e[0];
            repeat (4) @(posedge clk_i);
            rd(STATUS_ADDR, v);
            chk("capture flags", v & 8'h03, 8'(1 << ch));
         end
      end
      // modulation or one-pulse: only channel two captures
      lvl <= 2'b00;
      wr(COMPARE_TWO_ADDR, 8'hFC);
      for (int m = CTL_PWM_EN; m <= CTL_ONE_PULSE; m++) begin
         lvl <= 2'b00;
         wr(CONTROL_ADDR, 8'h19 | 8'(1 << m));
         wr(COUNTER_ADDR, 8'h00);
         wr(IRQ_CLEAR_ADDR, 8'h1F);
         // both pins rise on the selected edge; only channel two flags
         lvl <= 2'b11;
         repeat (4) @(posedge clk_i);
         rd(STATUS_ADDR, v);
         chk("mode capture flags", v & 8'h03, 8'h02);
      end
      // modulation spans, flags and interrupt
      for (int k = 0; k < 4; k++) begin
         c2 = (k == 0) ? 8'hFC : 8'(3 + $urandom % 30);
         c1 = (k == 0) ? 8'h00 : 8'($urandom % c2);
         l1 = (k < 2) ? 1'(k) : 1'($urandom);
         op = (k == 0) ? 1'b1 : 1'($urandom);
         wr(COMPARE_ONE_ADDR, c1);
         wr(COMPARE_TWO_ADDR, c2);
         wr(IRQ_ENABLE_ADDR, 8'h01);
         wr(CONTROL_ADDR, {1'b0, ~l1, l1, 2'b00, op, 2'b11});
         wr(COUNTER_ADDR, 8'h00);
         wr(IRQ_CLEAR_ADDR, 8'h1F);
         span(l1, n);
         span(~l1, n);
         span(l1, n);
         chk("level one span", 16'(n), ticks(c2 - c1));
         span(~l1, n);
         chk("level two span", 16'(n), ticks(c1 + 1));
         rd(STATUS_ADDR, v);
         chk("modulation flags", v & 8'h0D, 8'h01);
         wr(CONTROL_ADDR, 8'h00);
         chk("irq raised", irq, 1'b1);
         wr(IRQ_ENABLE_ADDR, 8'h00);
         chk("irq masked", irq, 1'b0);
         wr(IRQ_ENABLE_ADDR, 8'h01);
         wr(IRQ_CLEAR_ADDR, 8'h1F);
         chk("irq cleared", irq, 1'b0);
         rd(PIN_STATE_ADDR, v);
         chk("pin state", v, {7'h00, l1});
      end
      give_verdict();
   end
endmodule // tb_top
